// file: include/fps_pkg.sv
// Shared constants and types of the flash program/erase sequencer
package fps_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int SECT_LSB = 16;
    localparam int SECT_W = ADDR_W - SECT_LSB;
    localparam int N_SECT = 1 << SECT_W;

    // ----------------------------------------
    // Command sequence addresses and codes
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00AAA;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h00554;
    localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_PROG = 8'hA0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_RESUME = 8'h30;
    localparam logic [7:0] CODE_RESET = 8'hF0;

    // Position within a command sequence (count of writes already matched)
    localparam logic [2:0] SEQ_IDLE = 3'h0;
    localparam logic [2:0] SEQ_UL2 = 3'h1;
    localparam logic [2:0] SEQ_CMD = 3'h2;
    localparam logic [2:0] SEQ_ARG = 3'h3;
    localparam logic [2:0] SEQ_UL5 = 3'h4;
    localparam logic [2:0] SEQ_LAST = 3'h5;

    // ----------------------------------------
    // Status bit positions on a read
    // ----------------------------------------
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_LIMIT = 5;
    localparam int BIT_TIMER = 3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int ERASE_WIN_US = 50;
    localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
    localparam int SUSP_MAX_US = 15;
    localparam int SUSP_MAX_CYC = SUSP_MAX_US * CLK_MHZ;
    localparam int PROG_CYC_DEF = 320;
    localparam int PROG_LIMIT_DEF = 4000;
    localparam int PREP_CYC_DEF = 20000;
    localparam int ERASE_CYC_DEF = 100000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fps_wr_t;

    typedef enum logic [7:0] {
        ST_READ = 8'h01,
        ST_PROG = 8'h02,
        ST_LOCK = 8'h04,
        ST_PREP = 8'h08,
        ST_EWAIT = 8'h10,
        ST_ERASE = 8'h20,
        ST_SPEND = 8'h40,
        ST_SUSP = 8'h80
    } fps_state_t;

endpackage

// file: design/fps_timer.sv
// Loadable down counter used for algorithm and window timing
`timescale 1ns/10ps
`default_nettype none
module fps_timer #(
    parameter int W = 24
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic run,
    output logic [W-1:0] cnt_q,
    output logic zero
);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else if (load)
        begin
            cnt_q <= load_val;
        end
        else if (run && cnt_q != '0)
        begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign zero = (cnt_q == '0);

endmodule
`default_nettype wire

// file: design/fps_sequencer.sv
// Flash command sequencer: decodes write sequences, runs program/erase algorithms
//
// Functional notes
// - Program starts only after the fourth write, carrying address and data.
// - One program command writes at most one word, at any address.
// - A 0 bit never becomes 1; such a request ends in the limit error.
// - All commands are ignored while a program runs.
// - Hardware reset aborts programming at once.
// - Toggle bit freezes in the cycle the limit bit sets.
// - Chip erase is a six-write sequence, starting after the sixth.
// - Chip erase first programs every bit to 0 itself.
// - Sector erase: sixth write 30H to even address opens the wait window.
// - Each further 30H to an even address restarts the window; erase starts 50 us after last.
// - B0H during sector erase or its window suspends the erase.
// - Suspend code has no effect during chip erase or programming.
// - Suspend while already suspended is ignored.
// - Suspend in the wait window ends it and suspends at once.
// - Suspend during erasing reaches the suspended state within 15 us.
// - While suspended, reads outside erased sectors are normal; no programming.
// - 30H while suspended resumes the sector erase.
// - Resume code is ignored while erase runs unsuspended.
// - Status reads toggle bit 6 while an algorithm runs.
// - Window timer bit reads 0 in the window, 1 once erasing began.
// - Limit bit reads 1 after exceeding the pulse limit, else 0.
`timescale 1ns/10ps
`default_nettype none
module fps_sequencer #(
    parameter int OP_W = 24,
    parameter int unsigned PROG_CYC = fps_pkg::PROG_CYC_DEF,
    parameter int unsigned PROG_LIMIT = fps_pkg::PROG_LIMIT_DEF,
    parameter int unsigned PREP_CYC = fps_pkg::PREP_CYC_DEF,
    parameter int unsigned ERASE_CYC = fps_pkg::ERASE_CYC_DEF,
    parameter int unsigned SUSP_LAT = fps_pkg::SUSP_MAX_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_valid,
    input wire fps_pkg::fps_wr_t wr,
    input wire logic rd_valid,
    input wire logic [fps_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [fps_pkg::DATA_W-1:0] arr_rdata,
    input wire logic [fps_pkg::DATA_W-1:0] arr_cur_word,
    output logic [fps_pkg::DATA_W-1:0] rd_data_q,
    output logic busy_q,
    output logic susp_q,
    output logic err_q,
    output logic arr_we_q,
    output logic [fps_pkg::ADDR_W-1:0] arr_addr_q,
    output logic [fps_pkg::DATA_W-1:0] arr_wdata_q,
    output logic arr_zero_all_q,
    output logic arr_erase_q,
    output logic [fps_pkg::N_SECT-1:0] arr_erase_mask_q
);

    localparam int SUSP_BOUND = 300;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic cmd_is(input fps_pkg::fps_wr_t w, input logic [fps_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] c);
        cmd_is = (w.addr == a) && (w.data[7:0] == c);
    endfunction

    function automatic logic [fps_pkg::SECT_W-1:0] sect_of(input logic [fps_pkg::ADDR_W-1:0] a);
        sect_of = a[fps_pkg::ADDR_W-1:fps_pkg::SECT_LSB];
    endfunction

    fps_pkg::fps_state_t state_q, state_d;
    logic [2:0] seq_q, seq_d;
    logic seq_erase_q, seq_erase_d;
    logic start_prog, start_chip, start_sect;
    logic chip_q, toggle_q;
    logic [fps_pkg::DATA_W-1:0] prog_data_q, rdata_d;
    logic [8:0] susp_cnt_q;
    logic op_load, op_zero, win_load, win_zero, op_run;
    logic [OP_W-1:0] op_val, op_cnt;
    logic prog_viol, prog_done, sect_wr, susp_wr, resume_wr;

    assign sect_wr = wr_valid && wr.data[7:0] == fps_pkg::CODE_SECTOR && !wr.addr[0];
    assign susp_wr = wr_valid && wr.data[7:0] == fps_pkg::CODE_SUSPEND;
    assign resume_wr = wr_valid && wr.data[7:0] == fps_pkg::CODE_RESUME;

    // ----------------------------------------
    // Command sequence decode
    // ----------------------------------------
    always_comb
    begin
        seq_d = seq_q;
        seq_erase_d = seq_erase_q;
        start_prog = 1'b0;
        start_chip = 1'b0;
        start_sect = 1'b0;
        if (wr_valid && state_q == fps_pkg::ST_READ)
        begin
            seq_d = fps_pkg::SEQ_IDLE;
            case (seq_q)
                fps_pkg::SEQ_IDLE:
                    if (cmd_is(wr, fps_pkg::UNLOCK_A1, fps_pkg::CODE_UNLOCK1))
                        seq_d = fps_pkg::SEQ_UL2;
                fps_pkg::SEQ_UL2:
                    if (cmd_is(wr, fps_pkg::UNLOCK_A2, fps_pkg::CODE_UNLOCK2))
                        seq_d = fps_pkg::SEQ_CMD;
                fps_pkg::SEQ_CMD:
                begin
                    if (cmd_is(wr, fps_pkg::UNLOCK_A1, fps_pkg::CODE_PROG))
                    begin
                        seq_d = fps_pkg::SEQ_ARG;
                        seq_erase_d = 1'b0;
                    end
                    else if (cmd_is(wr, fps_pkg::UNLOCK_A1, fps_pkg::CODE_ERASE))
                    begin
                        seq_d = fps_pkg::SEQ_ARG;
                        seq_erase_d = 1'b1;
                    end
                end
                fps_pkg::SEQ_ARG:
                    if (!seq_erase_q)
                        start_prog = 1'b1;
                    else if (cmd_is(wr, fps_pkg::UNLOCK_A1, fps_pkg::CODE_UNLOCK1))
                        seq_d = fps_pkg::SEQ_UL5;
                fps_pkg::SEQ_UL5:
                    if (cmd_is(wr, fps_pkg::UNLOCK_A2, fps_pkg::CODE_UNLOCK2))
                        seq_d = fps_pkg::SEQ_LAST;
                fps_pkg::SEQ_LAST:
                    if (cmd_is(wr, fps_pkg::UNLOCK_A1, fps_pkg::CODE_CHIP))
                        start_chip = 1'b1;
                    else if (sect_wr)
                        start_sect = 1'b1;
                default:
                    seq_d = fps_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            seq_q <= fps_pkg::SEQ_IDLE;
            seq_erase_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            seq_erase_q <= seq_erase_d;
        end
    end

    // ----------------------------------------
    // Algorithm state machine
    // ----------------------------------------
    assign prog_viol = |(~arr_cur_word & prog_data_q);
    assign prog_done = (state_q == fps_pkg::ST_PROG) && !prog_viol && (op_cnt <= OP_W'(PROG_LIMIT - PROG_CYC));
    assign op_run = (state_q == fps_pkg::ST_PROG) || (state_q == fps_pkg::ST_PREP)
                    || (state_q == fps_pkg::ST_ERASE) || (state_q == fps_pkg::ST_SPEND);

    always_comb
    begin
        state_d = state_q;
        op_load = 1'b0;
        op_val = OP_W'(ERASE_CYC);
        win_load = 1'b0;
        case (state_q)
            fps_pkg::ST_READ:
                if (start_prog)
                begin
                    state_d = fps_pkg::ST_PROG;
                    op_load = 1'b1;
                    op_val = OP_W'(PROG_LIMIT);
                end
                else if (start_chip)
                begin
                    state_d = fps_pkg::ST_PREP;
                    op_load = 1'b1;
                    op_val = OP_W'(PREP_CYC);
                end
                else if (start_sect)
                begin
                    state_d = fps_pkg::ST_EWAIT;
                    win_load = 1'b1;
                end
            fps_pkg::ST_PROG:
                if (prog_done)
                    state_d = fps_pkg::ST_READ;
                else if (op_zero)
                    state_d = fps_pkg::ST_LOCK;
            fps_pkg::ST_LOCK:
                if (wr_valid && wr.data[7:0] == fps_pkg::CODE_RESET)
                    state_d = fps_pkg::ST_READ;
            fps_pkg::ST_PREP:
                if (op_zero)
                begin
                    state_d = fps_pkg::ST_ERASE;
                    op_load = 1'b1;
                end
            fps_pkg::ST_EWAIT:
                if (susp_wr)
                begin
                    state_d = fps_pkg::ST_SUSP;
                    op_load = 1'b1;
                end
                else if (sect_wr)
                    win_load = 1'b1;
                else if (win_zero)
                begin
                    state_d = fps_pkg::ST_ERASE;
                    op_load = 1'b1;
                end
            fps_pkg::ST_ERASE:
                if (op_zero)
                    state_d = fps_pkg::ST_READ;
                else if (susp_wr && !chip_q)
                    state_d = fps_pkg::ST_SPEND;
            fps_pkg::ST_SPEND:
                if (op_zero)
                    state_d = fps_pkg::ST_READ;
                else if (susp_cnt_q >= 9'(SUSP_LAT - 1))
                    state_d = fps_pkg::ST_SUSP;
            fps_pkg::ST_SUSP:
                if (resume_wr)
                    state_d = fps_pkg::ST_ERASE;
            default:
                state_d = fps_pkg::ST_READ;
        endcase
    end

    // Async reset drops any running algorithm; no array write is issued
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_q <= fps_pkg::ST_READ;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            susp_cnt_q <= '0;
        else if (state_q == fps_pkg::ST_SPEND)
            susp_cnt_q <= susp_cnt_q + 9'h001;
        else
            susp_cnt_q <= '0;
    end

    fps_timer #(.W(OP_W)) u_op_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(op_load),
        .load_val(op_val),
        .run(op_run),
        .cnt_q(op_cnt),
        .zero(op_zero)
    );

    fps_timer #(.W(OP_W)) u_win_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(win_load),
        .load_val(OP_W'(fps_pkg::ERASE_WIN_CYC)),
        .run(state_q == fps_pkg::ST_EWAIT),
        .cnt_q(),
        .zero(win_zero)
    );

    // ----------------------------------------
    // Error flag, erase scope and program latch
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            err_q <= 1'b0;
        else if (state_q == fps_pkg::ST_PROG && state_d == fps_pkg::ST_LOCK)
            err_q <= 1'b1;
        else if (state_d == fps_pkg::ST_READ)
            err_q <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            chip_q <= 1'b0;
            arr_erase_mask_q <= '0;
        end
        else if (start_chip)
        begin
            chip_q <= 1'b1;
            arr_erase_mask_q <= '1;
        end
        else if (start_sect || (state_q == fps_pkg::ST_EWAIT && sect_wr))
            arr_erase_mask_q[sect_of(wr.addr)] <= 1'b1;
        else if (state_q == fps_pkg::ST_READ)
        begin
            chip_q <= 1'b0;
            arr_erase_mask_q <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            arr_addr_q <= '0;
            prog_data_q <= '0;
        end
        else if (start_prog)
        begin
            arr_addr_q <= wr.addr;
            prog_data_q <= wr.data;
        end
    end

    // ----------------------------------------
    // Array commit strobes
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            arr_we_q <= 1'b0;
            arr_wdata_q <= '0;
            arr_zero_all_q <= 1'b0;
            arr_erase_q <= 1'b0;
        end
        else
        begin
            arr_we_q <= prog_done;
            arr_wdata_q <= prog_data_q & arr_cur_word;
            arr_zero_all_q <= state_q == fps_pkg::ST_PREP && op_zero;
            arr_erase_q <= (state_q == fps_pkg::ST_ERASE || state_q == fps_pkg::ST_SPEND) && op_zero;
        end
    end

    // ----------------------------------------
    // Status read path
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            toggle_q <= 1'b0;
        else if (rd_valid && op_run | (state_q == fps_pkg::ST_EWAIT) && !err_q)
            toggle_q <= !toggle_q;
    end

    always_comb
    begin
        rdata_d = arr_rdata;
        case (state_q)
            fps_pkg::ST_PROG, fps_pkg::ST_LOCK:
            begin
                rdata_d[fps_pkg::BIT_POLL] = !prog_data_q[fps_pkg::BIT_POLL];
                rdata_d[fps_pkg::BIT_TOGGLE] = toggle_q;
                rdata_d[fps_pkg::BIT_LIMIT] = err_q;
                rdata_d[fps_pkg::BIT_TIMER] = 1'b0;
            end
            fps_pkg::ST_PREP, fps_pkg::ST_ERASE, fps_pkg::ST_SPEND, fps_pkg::ST_EWAIT:
            begin
                rdata_d[fps_pkg::BIT_POLL] = 1'b0;
                rdata_d[fps_pkg::BIT_TOGGLE] = toggle_q;
                rdata_d[fps_pkg::BIT_LIMIT] = 1'b0;
                rdata_d[fps_pkg::BIT_TIMER] = state_q != fps_pkg::ST_EWAIT;
            end
            fps_pkg::ST_SUSP:
                if (arr_erase_mask_q[sect_of(rd_addr)])
                begin
                    rdata_d[fps_pkg::BIT_POLL] = 1'b1;
                    rdata_d[fps_pkg::BIT_TOGGLE] = 1'b1;
                    rdata_d[fps_pkg::BIT_LIMIT] = 1'b0;
                    rdata_d[fps_pkg::BIT_TIMER] = 1'b1;
                end
            default:
                rdata_d = arr_rdata;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= '0;
            busy_q <= 1'b0;
            susp_q <= 1'b0;
        end
        else
        begin
            if (rd_valid)
                rd_data_q <= rdata_d;
            busy_q <= state_d != fps_pkg::ST_READ && state_d != fps_pkg::ST_SUSP;
            susp_q <= state_d == fps_pkg::ST_SUSP;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_prog_start_fourth: assert property (@(posedge clk_sys) disable iff (rst)
        start_prog |=> state_q == fps_pkg::ST_PROG && arr_addr_q == $past(wr.addr))
        else $error("program did not start on fourth write");
    a_prog_single_word: assert property (@(posedge clk_sys) disable iff (rst)
        arr_we_q |=> !arr_we_q && state_q == fps_pkg::ST_READ)
        else $error("more than one word written");
    a_no_zero_rise: assert property (@(posedge clk_sys) disable iff (rst)
        arr_we_q |-> ($past(prog_data_q) & ~$past(arr_cur_word)) == '0)
        else $error("program turned a 0 bit into 1");
    a_prog_ignores_cmds: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == fps_pkg::ST_PROG && wr_valid && !prog_done && !op_zero) |=> state_q == fps_pkg::ST_PROG)
        else $error("command accepted during program");
    a_limit_freezes_toggle: assert property (@(posedge clk_sys) disable iff (rst)
        (err_q && rd_valid) |=> $stable(toggle_q) && rd_data_q[fps_pkg::BIT_LIMIT])
        else $error("toggle moved after limit error");
    a_chip_preprog: assert property (@(posedge clk_sys) disable iff (rst)
        start_chip |=> state_q == fps_pkg::ST_PREP ##0 (state_q == fps_pkg::ST_PREP) [*2])
        else $error("chip erase skipped preprogram");
    a_chip_no_suspend: assert property (@(posedge clk_sys) disable iff (rst)
        (chip_q && state_q == fps_pkg::ST_ERASE && susp_wr) |=> state_q != fps_pkg::ST_SPEND)
        else $error("suspend accepted during chip erase");
    a_window_suspend: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == fps_pkg::ST_EWAIT && susp_wr) |=> state_q == fps_pkg::ST_SUSP && susp_q)
        else $error("window suspend not immediate");
    a_suspend_latency: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(state_q == fps_pkg::ST_SPEND) |-> ##[1:SUSP_BOUND] state_q != fps_pkg::ST_SPEND)
        else $error("suspend took longer than limit");
    a_resume_restart: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == fps_pkg::ST_SUSP && resume_wr) |=> state_q == fps_pkg::ST_ERASE)
        else $error("resume did not restart erase");
    a_window_timer_bit: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_valid && state_q == fps_pkg::ST_EWAIT) |=> !rd_data_q[fps_pkg::BIT_TIMER])
        else $error("timer bit set inside window");
    a_bad_seq_drop: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == fps_pkg::ST_READ && wr_valid && seq_q == fps_pkg::SEQ_UL2
         && !cmd_is(wr, fps_pkg::UNLOCK_A2, fps_pkg::CODE_UNLOCK2)) |=> seq_q == fps_pkg::SEQ_IDLE)
        else $error("mismatched write kept sequence");

endmodule
`default_nettype wire

// file: dv/fps_array_model.sv
// Behavioural flash array answering the sequencer's array port
`timescale 1ns/10ps
`default_nettype none
module fps_array_model (
    input wire logic clk_sys,
    input wire logic [19:0] rd_addr,
    input wire logic arr_we_q,
    input wire logic [19:0] arr_addr_q,
    input wire logic [15:0] arr_wdata_q,
    input wire logic arr_zero_all_q,
    input wire logic arr_erase_q,
    input wire logic [15:0] arr_erase_mask_q,
    output logic [15:0] arr_rdata,
    output logic [15:0] arr_cur_word
);
    // Only sector and low four address bits are kept; tests leave the rest zero
    logic [15:0] mem [256];
    function automatic int ix(input logic [19:0] a);
        return int'({a[19:16], a[3:0]});
    endfunction
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    assign arr_rdata = mem[ix(rd_addr)];
    assign arr_cur_word = mem[ix(arr_addr_q)];
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 256; i++)
        begin
            if (arr_zero_all_q) mem[i] <= 16'h0000;
            if (arr_erase_q && arr_erase_mask_q[i >> 4]) mem[i] <= 16'hFFFF;
        end
        if (arr_we_q) mem[ix(arr_addr_q)] <= arr_wdata_q;
    end
endmodule
`default_nettype wire

// file: dv/test_fps_sequencer.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_fps_sequencer;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wr_valid = 1'b0;
    fps_pkg::fps_wr_t wr = '0;
    logic rd_valid = 1'b0;
    logic [19:0] rd_addr = '0;
    logic [19:0] arr_addr_q;
    logic [15:0] arr_rdata, arr_cur_word, rd_data_q, arr_wdata_q, arr_erase_mask_q, r, r2;
    logic busy_q, susp_q, err_q, arr_we_q, arr_zero_all_q, arr_erase_q;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    typedef struct {logic [19:0] a; logic [15:0] d;} fps_row_t;
    // Even addresses only, crossing sectors
    fps_row_t rows [4] = '{'{20'h10002, 16'h1234}, '{20'h20004, 16'h0F0F}, '{20'h3000E, 16'h00A5}, '{20'h0000A, 16'h8001}};
    fps_sequencer #(.PROG_CYC(4), .PROG_LIMIT(16), .PREP_CYC(8), .ERASE_CYC(20), .SUSP_LAT(3)) fps_sequencer_i (
        .clk_sys(clk_sys), .rst(rst), .wr_valid(wr_valid), .wr(wr), .rd_valid(rd_valid), .rd_addr(rd_addr),
        .arr_rdata(arr_rdata), .arr_cur_word(arr_cur_word), .rd_data_q(rd_data_q), .busy_q(busy_q),
        .susp_q(susp_q), .err_q(err_q), .arr_we_q(arr_we_q), .arr_addr_q(arr_addr_q), .arr_wdata_q(arr_wdata_q),
        .arr_zero_all_q(arr_zero_all_q), .arr_erase_q(arr_erase_q), .arr_erase_mask_q(arr_erase_mask_q));
    fps_array_model fps_array_model_i (
        .clk_sys(clk_sys), .rd_addr(rd_addr), .arr_we_q(arr_we_q), .arr_addr_q(arr_addr_q),
        .arr_wdata_q(arr_wdata_q), .arr_zero_all_q(arr_zero_all_q), .arr_erase_q(arr_erase_q),
        .arr_erase_mask_q(arr_erase_mask_q), .arr_rdata(arr_rdata), .arr_cur_word(arr_cur_word));
    always #25 clk_sys = ~clk_sys;
    task final_report;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic w(input logic [19:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        wr_valid = 1'b1;
        wr = {a, d};
        @(negedge clk_sys);
        wr_valid = 1'b0;
    endtask
    task automatic u(input logic [7:0] c);
        w(fps_pkg::UNLOCK_A1, 16'h00AA);
        w(fps_pkg::UNLOCK_A2, 16'h0055);
        w(fps_pkg::UNLOCK_A1, {8'h00, c});
    endtask
    task automatic rd(input logic [19:0] a);
        @(negedge clk_sys);
        rd_valid = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_valid = 1'b0;
        r = rd_data_q;
    endtask
    task automatic idle;
        @(negedge clk_sys);
        repeat (1500) if (busy_q === 1'b1) @(negedge clk_sys);
        `CHK(busy_q, 1'b0)
    endtask
    initial
    begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        foreach (rows[i])
        begin
            u(8'hA0);
            w(rows[i].a, rows[i].d);
            idle();
            rd(rows[i].a);
            `CHK(r, rows[i].d)
        end
        $display("program rows done");
        u(8'hA0);
        w(20'h3000E, 16'hFFFF);
        w(20'h00000, 16'h00B0);
        `CHK(susp_q, 1'b0)
        repeat (40) if (err_q !== 1'b1) @(negedge clk_sys);
        `CHK(err_q, 1'b1)
        rd(20'h3000E);
        r2 = r;
        rd(20'h3000E);
        `CHK(r[5], 1'b1)
        `CHK(r[6], r2[6])
        `CHK(r[7], 1'b0)
        w(20'h00000, 16'h00F0);
        idle();
        rd(20'h3000E);
        `CHK(r, 16'h00A5)
        $display("zero to one lock done");
        u(8'h80);
        w(fps_pkg::UNLOCK_A1, 16'h00AA);
        w(fps_pkg::UNLOCK_A2, 16'h0055);
        w(20'h10002, 16'h0030);
        rd(20'h10002);
        r2 = r;
        `CHK(r[3], 1'b0)
        rd(20'h10002);
        `CHK(r[6], ~r2[6])
        w(20'h20004, 16'h0030);
        w(20'h00000, 16'h00B0);
        @(negedge clk_sys);
        `CHK(susp_q, 1'b1)
        w(20'h00000, 16'h00B0);
        @(negedge clk_sys);
        `CHK(susp_q, 1'b1)
        rd(20'h10002);
        `CHK(r[3], 1'b1)
        u(8'hA0);
        w(20'h3000E, 16'h0000);
        rd(20'h3000E);
        `CHK(r, 16'h00A5)
        w(20'h00000, 16'h0030);
        @(negedge clk_sys);
        `CHK(susp_q, 1'b0)
        idle();
        rd(20'h20004);
        `CHK(r, 16'hFFFF)
        rd(20'h0000A);
        `CHK(r, 16'h8001)
        $display("sector erase suspend resume done");
        w(fps_pkg::UNLOCK_A1, 16'h00AA);
        w(fps_pkg::UNLOCK_A2, 16'h0056);
        w(fps_pkg::UNLOCK_A1, 16'h00A0);
        w(20'h0000C, 16'h0000);
        @(negedge clk_sys);
        `CHK(busy_q, 1'b0)
        u(8'h80);
        u(8'h10);
        repeat (10) @(negedge clk_sys);
        w(20'h00000, 16'h00B0);
        @(negedge clk_sys);
        `CHK(susp_q, 1'b0)
        idle();
        rd(20'h0000A);
        `CHK(r, 16'hFFFF)
        $display("mismatch and chip erase done");
        u(8'h80);
        u(8'h30);
        repeat (1005) @(negedge clk_sys);
        w(20'h00000, 16'h0030);
        `CHK(busy_q, 1'b1)
        `CHK(susp_q, 1'b0)
        w(20'h00000, 16'h00B0);
        repeat (4) @(negedge clk_sys);
        `CHK(susp_q, 1'b1)
        w(20'h00000, 16'h0030);
        idle();
        $display("suspend during erase done");
        u(8'hA0);
        w(20'h0000A, 16'h0000);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        `CHK(busy_q, 1'b0)
        rd(20'h0000A);
        `CHK(r, 16'hFFFF)
        $display("reset abort done");
        final_report();
    end
endmodule
`default_nettype wire
